// [verilog/isspi_pkg.sv]
// Overview of operation
// - most significant output bit appears as soon as chip select falls.
// - later output bits shift out after serial clock falling edges.
// - data out is released to high impedance while chip select is high.
// - link uses clock polarity 1 and clock phase 1.
// - data in is sampled on serial clock rising edges.
// - a frame is exactly 16 clocks, 16 bits each way at once.
// - serial clock and data in are ignored while chip select is high.
package isspi_pkg;
    localparam int WORD_BITS = 16;
    localparam logic [7:0] FAST_MAX_SETTING = 8'h09;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RATE_FAST_NS = 40_000;
    localparam int RATE_NORM_NS = 160_000;
    localparam int STALL_FAST_NS = 9_000;
    localparam int STALL_NORM_NS = 75_000;
    // least times round up to whole cycles
    localparam int RATE_FAST_CYC = (RATE_FAST_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam int RATE_NORM_CYC = (RATE_NORM_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam int STALL_FAST_CYC = (STALL_FAST_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam int STALL_NORM_CYC = (STALL_NORM_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam int CNT_BITS = 13;
    localparam logic [CNT_BITS-1:0] CNT_RESET = 13'h0000;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ISSPI_IDLE = 2'b00,
        ISSPI_FRAME = 2'b01,
        ISSPI_GAP = 2'b11
    } isspi_state_t;

    typedef struct packed {
        logic rate_err;
        logic stall_err;
        logic short_err;
    } isspi_status_t;

    localparam isspi_status_t STATUS_RESET = '{1'b0, 1'b0, 1'b0};
endpackage

// [verilog/isspi_link.sv]
`timescale 1ns/100ps
// runs on the master's serial clock; counters are cleared by chip select
// itself, so no edge outside a frame is ever needed
module isspi_link (
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic rstn,
    input wire logic din,
    input wire logic [isspi_pkg::WORD_BITS-1:0] tx_word,
    output logic dout,
    output logic dout_oe,
    output logic [isspi_pkg::WORD_BITS-1:0] rx_word,
    output logic done_tgl
);
    logic [4:0] rise_q, rise_d;
    logic [3:0] out_idx_q, out_idx_d;
    logic [isspi_pkg::WORD_BITS-1:0] rx_sh_q, rx_sh_d;
    logic [isspi_pkg::WORD_BITS-1:0] rx_word_q, rx_word_d;
    logic done_tgl_q, done_tgl_d;

    always_comb begin
        rise_d = (rise_q == 5'd16) ? rise_q : rise_q + 5'd1;
        rx_sh_d = {rx_sh_q[isspi_pkg::WORD_BITS-2:0], din};
        rx_word_d = rx_word_q;
        done_tgl_d = done_tgl_q;
        if (rise_q == 5'd15) begin
            rx_word_d = rx_sh_d;
            done_tgl_d = ~done_tgl_q;
        end
        // first falling edge keeps the msb; each later one follows a rise
        if (rise_q == 5'd0) begin
            out_idx_d = 4'd0;
        end else if (rise_q >= 5'd16) begin
            out_idx_d = 4'd15;
        end else begin
            out_idx_d = rise_q[3:0];
        end
    end

    // chip select high holds the frame logic cleared: sclk ignored
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rise_q <= 5'd0;
            rx_sh_q <= isspi_pkg::WORD_RESET;
        end else begin
            rise_q <= rise_d;
            rx_sh_q <= rx_sh_d;
        end
    end

    always_ff @(posedge sclk or negedge rstn) begin
        if (!rstn) begin
            rx_word_q <= isspi_pkg::WORD_RESET;
            done_tgl_q <= 1'b0;
        end else begin
            rx_word_q <= rx_word_d;
            done_tgl_q <= done_tgl_d;
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            out_idx_q <= 4'd0;
        end else begin
            out_idx_q <= out_idx_d;
        end
    end

    // msb is a pure function of the index, so it shows at chip select fall
    assign dout = tx_word[4'd15 - out_idx_q];
    assign dout_oe = ~cs_n;
    assign rx_word = rx_word_q;
    assign done_tgl = done_tgl_q;
endmodule

// [verilog/isspi_top.sv]
`timescale 1ns/100ps
module isspi_top (
    input wire logic clock,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout_o,
    output logic dout_oe,
    input wire logic [7:0] sample_period_setting,
    input wire logic [isspi_pkg::WORD_BITS-1:0] tx_word,
    output logic tx_taken,
    output logic [isspi_pkg::WORD_BITS-1:0] rx_data,
    output logic rx_valid,
    output logic fast_mode,
    output isspi_pkg::isspi_status_t status
);
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] cs_sync_q;
    logic [2:0] done_sync_q;
    logic done_tgl;
    logic [isspi_pkg::WORD_BITS-1:0] link_word;
    logic [isspi_pkg::WORD_BITS-1:0] tx_hold_q, tx_hold_d;
    logic [isspi_pkg::WORD_BITS-1:0] rx_data_q, rx_data_d;
    logic rx_valid_q, rx_valid_d;
    logic tx_taken_q, tx_taken_d;
    logic fast_q, fast_d;
    logic got_word_q, got_word_d;
    logic [isspi_pkg::CNT_BITS-1:0] period_q, period_d;
    logic [isspi_pkg::CNT_BITS-1:0] gap_q, gap_d;
    isspi_pkg::isspi_state_t state_q, state_d;
    isspi_pkg::isspi_status_t status_q, status_d;
    logic cs_low, done_ev;

    function automatic logic [isspi_pkg::CNT_BITS-1:0] sat_inc(
        input logic [isspi_pkg::CNT_BITS-1:0] v
    );
        sat_inc = (&v) ? v : v + 13'h0001;
    endfunction

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    isspi_link u_link (
        .sclk(sclk),
        .cs_n(cs_n),
        .rstn(rst_n),
        .din(din),
        .tx_word(tx_hold_q),
        .dout(dout_o),
        .dout_oe(dout_oe),
        .rx_word(link_word),
        .done_tgl(done_tgl)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_q <= 2'b11;
            done_sync_q <= 3'b000;
        end else begin
            cs_sync_q <= {cs_sync_q[0], cs_n};
            done_sync_q <= {done_sync_q[1:0], done_tgl};
        end
    end
    assign cs_low = ~cs_sync_q[1];
    assign done_ev = done_sync_q[2] ^ done_sync_q[1];

    always_comb begin
        fast_d = (sample_period_setting <= isspi_pkg::FAST_MAX_SETTING);
        state_d = state_q;
        tx_hold_d = tx_hold_q;
        tx_taken_d = 1'b0;
        rx_valid_d = 1'b0;
        // link word is stable for a whole frame after its toggle
        rx_data_d = done_ev ? link_word : rx_data_q;
        got_word_d = got_word_q | done_ev;
        period_d = sat_inc(period_q);
        gap_d = gap_q;
        status_d = status_q;
        status_d.rate_err = 1'b0;
        status_d.stall_err = 1'b0;
        status_d.short_err = 1'b0;
        if (done_ev) begin
            rx_valid_d = 1'b1;
        end
        case (state_q)
            isspi_pkg::ISSPI_IDLE: begin
                // tx word only follows the user while no frame is open
                tx_hold_d = tx_word;
                if (cs_low) begin
                    state_d = isspi_pkg::ISSPI_FRAME;
                    tx_taken_d = 1'b1;
                    period_d = isspi_pkg::CNT_RESET;
                    got_word_d = done_ev;
                end
            end
            isspi_pkg::ISSPI_FRAME: begin
                if (!cs_low) begin
                    state_d = isspi_pkg::ISSPI_GAP;
                    gap_d = isspi_pkg::CNT_RESET;
                    status_d.short_err = ~got_word_d;
                end
            end
            isspi_pkg::ISSPI_GAP: begin
                tx_hold_d = tx_word;
                gap_d = sat_inc(gap_q);
                if (cs_low) begin
                    state_d = isspi_pkg::ISSPI_FRAME;
                    tx_taken_d = 1'b1;
                    got_word_d = done_ev;
                    period_d = isspi_pkg::CNT_RESET;
                    // limits follow the current mode, flagged per frame
                    if (fast_q) begin
                        status_d.rate_err = (period_q <
                            isspi_pkg::CNT_BITS'(isspi_pkg::RATE_FAST_CYC));
                        status_d.stall_err = (gap_q <
                            isspi_pkg::CNT_BITS'(isspi_pkg::STALL_FAST_CYC));
                    end else begin
                        status_d.rate_err = (period_q <
                            isspi_pkg::CNT_BITS'(isspi_pkg::RATE_NORM_CYC));
                        status_d.stall_err = (gap_q <
                            isspi_pkg::CNT_BITS'(isspi_pkg::STALL_NORM_CYC));
                    end
                end
            end
            default: begin
                state_d = isspi_pkg::ISSPI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= isspi_pkg::ISSPI_IDLE;
            tx_hold_q <= isspi_pkg::WORD_RESET;
            tx_taken_q <= 1'b0;
            rx_data_q <= isspi_pkg::WORD_RESET;
            rx_valid_q <= 1'b0;
            fast_q <= 1'b0;
            got_word_q <= 1'b0;
            period_q <= isspi_pkg::CNT_RESET;
            gap_q <= isspi_pkg::CNT_RESET;
            status_q <= isspi_pkg::STATUS_RESET;
        end else begin
            state_q <= state_d;
            tx_hold_q <= tx_hold_d;
            tx_taken_q <= tx_taken_d;
            rx_data_q <= rx_data_d;
            rx_valid_q <= rx_valid_d;
            fast_q <= fast_d;
            got_word_q <= got_word_d;
            period_q <= period_d;
            gap_q <= gap_d;
            status_q <= status_d;
        end
    end

    assign tx_taken = tx_taken_q;
    assign rx_data = rx_data_q;
    assign rx_valid = rx_valid_q;
    assign fast_mode = fast_q;
    assign status = status_q;
endmodule

// [test/isspi_checker.sv]
`timescale 1ns/100ps
module isspi_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic [7:0] sample_period_setting,
    input wire logic [isspi_pkg::WORD_BITS-1:0] tx_word,
    input wire logic tx_taken,
    input wire logic rx_valid,
    input wire logic fast_mode,
    input wire isspi_pkg::isspi_status_t status
);
    // the design's own reset copy lags rstn by two flops
    logic [2:0] age_q;
    logic [2:0] age_d;
    always_comb age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) age_q <= 3'h0;
        else age_q <= age_d;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn || age_q < 3'h6);
    AST_OE: assert property (dout_oe == !cs_n)
        else $error("drive enable not inverse of select");
    AST_MSB: assert property ($fell(cs_n) |-> dout_o == tx_word[15])
        else $error("top bit not out at select fall");
    AST_QUIET: assert property (cs_n [*8] |-> !rx_valid && !tx_taken)
        else $error("activity while deselected");
    AST_ERR_AT_START: assert property (
        status.rate_err || status.stall_err |-> !cs_n)
        else $error("spacing flag outside frame start");
    AST_MODE: assert property (1'b1 |=> fast_mode ==
        ($past(sample_period_setting) <= isspi_pkg::FAST_MAX_SETTING))
        else $error("mode does not follow setting");
    AST_TAKEN: assert property ($fell(cs_n) |-> ##[2:4] tx_taken)
        else $error("frame start not reported");
    AST_TPULSE: assert property (tx_taken |=> !tx_taken)
        else $error("taken pulse too long");
    AST_RPULSE: assert property (rx_valid |=> !rx_valid)
        else $error("valid pulse too long");
    AST_SHORT: assert property (status.short_err |-> cs_n && !rx_valid)
        else $error("short frame gave a word");
    cover property (rx_valid);
    cover property (status.short_err);
    cover property (status.stall_err && !fast_mode);
endmodule

bind isspi_top isspi_checker isspi_checker_inst (.clock(clock), .rstn(rstn),
    .cs_n(cs_n), .dout_o(dout_o), .dout_oe(dout_oe),
    .sample_period_setting(sample_period_setting), .tx_word(tx_word),
    .tx_taken(tx_taken), .rx_valid(rx_valid), .fast_mode(fast_mode),
    .status(status));

// [test/isspi_master.sv]
`timescale 1ns/100ps
module isspi_master (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout_o,
    output logic [15:0] got
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        got = 16'h0000;
    end
    // clock stands high outside frames; din inverts once released
    task automatic frame(input logic [15:0] w, input int n, input int gap);
        cs_n = 1'b0;
        #60;
        for (int i = 0; i < n; i++) begin
            sclk = 1'b0;
            din = w[15-i];
            #7.5;
            sclk = 1'b1;
            got = {got[14:0], dout_o};
            #7.5;
        end
        #10;
        cs_n = 1'b1;
        din = ~din;
        #gap;
    endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/100ps
module testbench;
    logic clock, rstn, sclk, cs_n, din, dout_o, dout_oe;
    logic tx_taken, rx_valid, fast_mode;
    logic [7:0] sample_period_setting;
    logic [15:0] tx_word, rx_data, got;
    logic [2:0] seen;
    isspi_pkg::isspi_status_t status;
    logic [15:0] q[$];
    int fail_count, tests_run;
    isspi_top isspi_top_inst (.clock(clock), .rstn(rstn), .sclk(sclk),
        .cs_n(cs_n), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
        .sample_period_setting(sample_period_setting), .tx_word(tx_word),
        .tx_taken(tx_taken), .rx_data(rx_data), .rx_valid(rx_valid),
        .fast_mode(fast_mode), .status(status));
    isspi_master isspi_master_inst (.sclk(sclk), .cs_n(cs_n), .din(din),
        .dout_o(dout_o), .got(got));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic cmp(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wrap_up;
        $display("fails %0d checks %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clock) begin
        if (rx_valid === 1'b1) begin
            cmp({15'h0000, q.size() != 0}, 16'h0001);
            if (q.size() != 0) cmp(rx_data, q.pop_front());
        end
        seen <= seen | status;
    end
    task automatic run(input logic [7:0] s, input int n, input int gap);
        logic [15:0] t;
        logic [15:0] r;
        t = 16'($urandom);
        r = 16'($urandom);
        @(posedge clock);
        #2;
        sample_period_setting = s;
        tx_word = t;
        repeat (4) @(posedge clock);
        #2 cmp({15'h0000, fast_mode}, {15'h0000, s <= 8'h09});
        if (n == 16) q.push_back(r);
        isspi_master_inst.frame(r, n, gap);
        if (n == 16) cmp(got, t);
        cmp({15'h0000, dout_oe}, 16'h0000);
    endtask
    initial begin
        rstn = 1'b0;
        sample_period_setting = 8'h00;
        tx_word = 16'h0000;
        seen = 3'b000;
        fail_count = 0;
        tests_run = 0;
        void'($urandom(62380));
        repeat (8) @(posedge clock);
        #2 rstn = 1'b1;
        run(8'h00, 16, 45000);
        run(8'h09, 16, 45000);
        seen = 3'b000;
        run(8'h09, 16, 45000);
        cmp({13'h0000, seen}, 16'h0000);
        run(8'h0A, 16, 45000);
        seen = 3'b000;
        run(8'h0A, 16, 1000);
        cmp({13'h0000, seen}, 16'h0006);
        seen = 3'b000;
        run(8'h05, 16, 170000);
        cmp({13'h0000, seen}, 16'h0006);
        run(8'(8'h0A + $urandom % 246), 16, 170000);
        for (int i = 0; i < 3; i++) run(8'($urandom % 10), 16, 45000);
        seen = 3'b000;
        run(8'h03, 8, 45000);
        cmp({13'h0000, seen}, 16'h0001);
        run(8'h01, 16, 45000);
        repeat (8) @(posedge clock);
        cmp(16'(q.size()), 16'h0000);
        wrap_up;
    end
    initial begin
        #3_000_000;
        fail_count++;
        wrap_up;
    end
endmodule
